//--- core/hvp_pkg.sv
// Purpose: shared constants and types for the parallel programming port
// Assumes: 125 MHz system clock
// Notes: memory sizes scaled by module parameters
package hvp_pkg;
  // ==========================================
  // pin actions and commands
  localparam logic [1:0] ACT_ADDR = 2'h0;
  localparam logic [1:0] ACT_DATA = 2'h1;
  localparam logic [1:0] ACT_CMD = 2'h2;
  localparam logic [7:0] CMD_ERASE = 8'h80;
  localparam logic [7:0] CMD_WFUSE = 8'h40;
  localparam logic [7:0] CMD_WLOCK = 8'h20;
  localparam logic [7:0] CMD_WFLASH = 8'h10;
  localparam logic [7:0] CMD_WEEP = 8'h11;
  localparam logic [7:0] CMD_RSIG = 8'h08;
  localparam logic [7:0] CMD_RFUSE = 8'h04;
  localparam logic [7:0] CMD_RFLASH = 8'h02;
  localparam logic [7:0] CMD_REEP = 8'h03;
  localparam logic [7:0] CMD_NOP = 8'h00;
  // ==========================================
  // geometry and reset values
  localparam int FLASH_PAGE_BITS = 7;
  localparam int EEP_PAGE_BITS = 3;
  localparam int EEPROM_PRESERVE_FUSE_BIT = 3;
  localparam logic [7:0] FUSE_LO_RST = 8'h62;
  localparam logic [7:0] FUSE_HI_RST = 8'h99;
  localparam logic [7:0] FUSE_EX_RST = 8'hff;
  localparam logic [7:0] LOCK_RST = 8'hff;
  localparam logic [7:0] PINS_IDLE = 8'h60; // write and oe high, strobes and selects low
  localparam logic [7:0] SIG_ADDR_CAL = 8'h00;
  localparam logic [7:0] SIG_ADDR_SER = 8'h0e;
  localparam int CLK_MHZ = 125;
  localparam int PROG_NS = 400;
  localparam int PROG_CYC = (PROG_NS * CLK_MHZ + 999) / 1000;
  // ==========================================
  // grouped pin bundle
  typedef struct packed {
    logic loadStrobe;
    logic writeN;
    logic outEnN;
    logic pageLatch;
    logic [1:0] actSel;
    logic [1:0] byteSel;
  } hvp_pins_type;
endpackage

//--- core/hvp_port.sv
// Purpose: device side of the high-voltage parallel programming port
// Assumes: pins asynchronous to clk; rst stands for reset pin at 0V or power off
// Notes: a nonvolatile write is modelled as a fixed busy time
// Behaviour
// - load strobe acts on action select pins
// - decode the ten command bytes
// - write/output strobes run loaded command
// - ready_busy low while operation runs
// - drive data bus only while oe low
// - byte selects choose address/data/fuse byte
// - fuse/lock read byte chosen by selects
// - reset leaves programming mode
// - command and address retained across operations
// - erase clears flash eeprom locks, not fuses
// - preserve fuse keeps eeprom through erase
// - erase starts on write, busy until done
// - flash page buffer 128 words, pc split
// - eeprom pages of eight bytes
// - data load picks low/high by select
// - page latch copies data into buffer
// - three signature bytes readable even locked
// - calibration byte copied at every reset
// - nine serial number bytes in signature space
// - page write starts on write, busy
// - nop command ends page programming
`timescale 1ns/1ps
module hvp_port #(
  parameter int FLASH_AW = 15,
  parameter int EEP_AW = 11,
  parameter logic [7:0] SIG0 = 8'h5a, // arbitrary identity value
  parameter logic [7:0] SIG1 = 8'h3c, // arbitrary identity value
  parameter logic [7:0] SIG2 = 8'h01, // arbitrary identity value
  parameter logic [7:0] CAL_BYTE = 8'h80,
  parameter logic [71:0] SERIAL = 72'h0123456789abcdef42
) (
  input wire logic clk,
  input wire logic rst,
  input wire hvp_pkg::hvp_pins_type pins,
  input wire logic [7:0] dataIn,
  output logic [7:0] dataOut,
  output logic dataOe,
  output logic ready_busy_out,
  output logic [7:0] osc_calibration_reg
);
  import hvp_pkg::*;
  localparam int FW = 1 << FLASH_AW;
  localparam int EW = 1 << EEP_AW;

  // ==========================================
  // pin synchronisers
  hvp_pins_type s1_ff, s2_ff, s3_ff;
  logic [7:0] din1_ff, din2_ff;
  // reset to the idle pin levels: a zero start would read as oe low and drive the bus
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_ff <= hvp_pins_type'(PINS_IDLE);
      s2_ff <= hvp_pins_type'(PINS_IDLE);
      s3_ff <= hvp_pins_type'(PINS_IDLE);
      din1_ff <= '0;
      din2_ff <= '0;
    end else begin
      s1_ff <= pins;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      din1_ff <= dataIn;
      din2_ff <= din1_ff;
    end
  end
  wire loadPulse = s2_ff.loadStrobe & ~s3_ff.loadStrobe;
  wire latchPulse = s2_ff.pageLatch & ~s3_ff.pageLatch;
  wire wrPulse = ~s2_ff.writeN & s3_ff.writeN;
  wire [1:0] bsel = s2_ff.byteSel;

  // ==========================================
  // command, address and data latches
  logic [7:0] cmd_ff, adrLo_ff, adrHi_ff, datLo_ff, datHi_ff;
  logic busy_ff;
  logic [8:0] cnt_ff;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin // reset pin low leaves programming mode
      cmd_ff <= CMD_NOP;
      adrLo_ff <= '0;
      adrHi_ff <= '0;
      datLo_ff <= '0;
      datHi_ff <= '0;
    end else if (loadPulse) begin
      unique case (s2_ff.actSel)
        ACT_ADDR: begin
          if (bsel == 2'h0) adrLo_ff <= din2_ff;
          else if (bsel == 2'h1) adrHi_ff <= din2_ff;
        end
        ACT_DATA: begin
          if (bsel[0]) datHi_ff <= din2_ff;
          else datLo_ff <= din2_ff;
        end
        ACT_CMD: if (!busy_ff) cmd_ff <= din2_ff; // held values persist
        default: ;
      endcase
    end
  end
  wire [15:0] addr = {adrHi_ff, adrLo_ff};
  wire cmdLoad = loadPulse && s2_ff.actSel == ACT_CMD && !busy_ff;

  // ==========================================
  // memories and page buffers
  logic [15:0] flash [FW];
  logic [15:0] fbuf [1 << FLASH_PAGE_BITS];
  logic [7:0] eep [EW];
  logic [7:0] ebuf [1 << EEP_PAGE_BITS];
  logic [(1 << EEP_PAGE_BITS)-1:0] ebufVal_ff;
  logic [7:0] fuseLo_ff, fuseHi_ff, fuseEx_ff, lock_ff;
  logic writesArmed_ff;
  wire [FLASH_PAGE_BITS-1:0] word_in_page_index = addr[FLASH_PAGE_BITS-1:0];
  wire [FLASH_AW-FLASH_PAGE_BITS-1:0] page_index = addr[FLASH_AW-1:FLASH_PAGE_BITS];
  wire [EEP_PAGE_BITS-1:0] eepByte = addr[EEP_PAGE_BITS-1:0];
  wire eeprom_preserve_fuse = ~fuseHi_ff[EEPROM_PRESERVE_FUSE_BIT];

  // page latch fills the buffer for the current command; a fresh command or a finished
  // commit blanks it, so slots that were never latched leave the memory as it was
  always_ff @(posedge clk) begin
    if (cmdLoad || (busy_ff && cnt_ff == '0)) begin
      for (int i = 0; i < (1 << FLASH_PAGE_BITS); i++) fbuf[i] <= 16'hffff;
      ebufVal_ff <= '0;
    end else if (latchPulse && writesArmed_ff) begin
      if (cmd_ff == CMD_WFLASH) fbuf[word_in_page_index] <= {datHi_ff, datLo_ff};
      if (cmd_ff == CMD_WEEP) begin
        ebuf[eepByte] <= datLo_ff;
        ebufVal_ff[eepByte] <= 1'b1;
      end
    end
  end

  // write strobe starts the long operation; busy stays for PROG_CYC
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busy_ff <= 1'b0;
      cnt_ff <= '0;
    end else if (wrPulse && !busy_ff && writesArmed_ff) begin
      busy_ff <= 1'b1;
      cnt_ff <= 9'(PROG_CYC - 1);
    end else if (busy_ff) begin
      if (cnt_ff == '0) busy_ff <= 1'b0;
      else cnt_ff <= cnt_ff - 9'h1;
    end
  end
  wire doneOp = busy_ff && cnt_ff == '0;

  // a fresh write command arms writes; nop and reads disarm them
  always_ff @(posedge clk or posedge rst) begin
    if (rst) writesArmed_ff <= 1'b0;
    else if (cmdLoad)
      writesArmed_ff <= din2_ff inside {CMD_ERASE, CMD_WFUSE, CMD_WLOCK, CMD_WFLASH, CMD_WEEP};
  end

  // commit the operation at the end of the busy time
  always_ff @(posedge clk) begin
    if (doneOp) begin
      unique case (cmd_ff)
        CMD_ERASE: begin
          for (int i = 0; i < FW; i++) flash[i] <= 16'hffff;
          if (!eeprom_preserve_fuse)
            for (int i = 0; i < EW; i++) eep[i] <= 8'hff;
        end
        CMD_WFLASH:
          for (int i = 0; i < (1 << FLASH_PAGE_BITS); i++)
            flash[{page_index, FLASH_PAGE_BITS'(i)}] <= flash[{page_index, FLASH_PAGE_BITS'(i)}] & fbuf[i];
        CMD_WEEP:
          for (int i = 0; i < (1 << EEP_PAGE_BITS); i++)
            if (ebufVal_ff[i]) // only latched bytes are written
              eep[{addr[EEP_AW-1:EEP_PAGE_BITS], EEP_PAGE_BITS'(i)}] <= ebuf[i];
        default: ;
      endcase
    end
  end

  // fuses and locks; lock clears only once the erase has finished
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fuseLo_ff <= FUSE_LO_RST;
      fuseHi_ff <= FUSE_HI_RST;
      fuseEx_ff <= FUSE_EX_RST;
      lock_ff <= LOCK_RST;
    end else if (doneOp) begin
      if (cmd_ff == CMD_ERASE) lock_ff <= LOCK_RST;
      if (cmd_ff == CMD_WLOCK) lock_ff <= lock_ff & datLo_ff;
      if (cmd_ff == CMD_WFUSE) begin
        if (bsel == 2'h0) fuseLo_ff <= datLo_ff;
        else if (bsel == 2'h1) fuseHi_ff <= datLo_ff;
        else if (bsel == 2'h2) fuseEx_ff <= datLo_ff;
      end
    end
  end

  // ==========================================
  // read path and bus drive
  logic [7:0] rd;
  always_comb begin
    rd = 8'h00;
    unique case (cmd_ff)
      CMD_RFLASH: rd = bsel[0] ? flash[addr[FLASH_AW-1:0]][15:8] : flash[addr[FLASH_AW-1:0]][7:0];
      CMD_REEP: rd = eep[addr[EEP_AW-1:0]];
      CMD_RFUSE: begin
        unique case (bsel)
          2'h0: rd = fuseLo_ff;
          2'h1: rd = lock_ff;
          2'h2: rd = fuseEx_ff;
          2'h3: rd = fuseHi_ff;
        endcase
      end
      CMD_RSIG: begin // never gated by lock bits
        if (bsel[0] && adrLo_ff == SIG_ADDR_CAL) rd = CAL_BYTE;
        else if (adrLo_ff == 8'h00) rd = SIG0;
        else if (adrLo_ff == 8'h01) rd = SIG1;
        else if (adrLo_ff == 8'h02) rd = SIG2;
        else if (adrLo_ff >= SIG_ADDR_SER && adrLo_ff < SIG_ADDR_SER + 8'h09)
          rd = SERIAL[8 * (adrLo_ff - SIG_ADDR_SER) +: 8];
      end
      default: rd = 8'h00;
    endcase
  end

  // outputs registered; oe released on the third clock after oe pin rises (two synchroniser stages plus this register)
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dataOe <= 1'b0;
      dataOut <= '0;
      ready_busy_out <= 1'b1;
    end else begin
      dataOe <= ~s2_ff.outEnN;
      dataOut <= rd;
      ready_busy_out <= ~(busy_ff | (wrPulse & writesArmed_ff));
    end
  end

  // calibration value reloaded on every reset
  logic calDone_ff;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) osc_calibration_reg <= 8'h00;
    else if (!calDone_ff) osc_calibration_reg <= CAL_BYTE;
  end
  // marks the single copy cycle after each reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) calDone_ff <= 1'b0;
    else calDone_ff <= 1'b1;
  end

  // ==========================================
  // checks
  // helper count of busy cycles, so the busy length is checked without a long repeat
  logic [8:0] busyLen_ff;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) busyLen_ff <= '0;
    else if (!busy_ff) busyLen_ff <= '0;
    else busyLen_ff <= busyLen_ff + 9'h1;
  end
  busy_len_a: assert property (@(posedge clk) disable iff (rst)
    $rose(busy_ff) |-> busy_ff [*3]) else $error("busy too short");
  busy_time_a: assert property (@(posedge clk) disable iff (rst)
    $fell(busy_ff) |-> busyLen_ff == 9'(PROG_CYC)) else $error("busy time wrong");
  rb_low_a: assert property (@(posedge clk) disable iff (rst)
    busy_ff |=> !ready_busy_out) else $error("ready while busy");
  rb_high_a: assert property (@(posedge clk) disable iff (rst)
    $fell(busy_ff) && !wrPulse |=> ready_busy_out) else $error("ready not restored");
  oe_follow_a: assert property (@(posedge clk) disable iff (rst)
    s2_ff.outEnN |=> !dataOe) else $error("bus driven with oe high");
  oe_drive_a: assert property (@(posedge clk) disable iff (rst)
    !s2_ff.outEnN |=> dataOe) else $error("bus not driven with oe low");
  cmd_keep_a: assert property (@(posedge clk) disable iff (rst)
    !cmdLoad |=> $stable(cmd_ff)) else $error("command changed");
  cmd_busy_a: assert property (@(posedge clk) disable iff (rst)
    busy_ff |=> $stable(cmd_ff)) else $error("command changed while busy");
  idle_act_a: assert property (@(posedge clk) disable iff (rst)
    loadPulse && s2_ff.actSel == 2'h3 |=> $stable({cmd_ff, addr, datHi_ff, datLo_ff}))
    else $error("idle action changed a latch");
  nop_disarm_a: assert property (@(posedge clk) disable iff (rst)
    cmdLoad && din2_ff == CMD_NOP |=> !writesArmed_ff) else $error("nop kept writes");
  wr_refuse_a: assert property (@(posedge clk) disable iff (rst)
    wrPulse && !writesArmed_ff && !busy_ff |=> !busy_ff)
    else $error("unarmed write started");
  lock_rd_a: assert property (@(posedge clk) disable iff (rst)
    cmd_ff == CMD_RFUSE && bsel == 2'h1 |=> dataOut == $past(lock_ff))
    else $error("lock read wrong");
  sig_rd_a: assert property (@(posedge clk) disable iff (rst)
    cmd_ff == CMD_RSIG && !bsel[0] && adrLo_ff == 8'h00 |=> dataOut == SIG0)
    else $error("signature read wrong");
  erase_lock_a: assert property (@(posedge clk) disable iff (rst)
    doneOp && cmd_ff == CMD_ERASE |=> lock_ff == LOCK_RST)
    else $error("locks kept by erase");
  fuse_keep_a: assert property (@(posedge clk) disable iff (rst)
    doneOp && cmd_ff == CMD_ERASE |=> $stable({fuseLo_ff, fuseHi_ff, fuseEx_ff}))
    else $error("fuses changed by erase");
  cal_a: assert property (@(posedge clk) disable iff (rst)
    calDone_ff |-> osc_calibration_reg == CAL_BYTE) else $error("cal not loaded");
  dlo_a: assert property (@(posedge clk) disable iff (rst)
    loadPulse && s2_ff.actSel == ACT_DATA && !bsel[0] |=> datLo_ff == $past(din2_ff))
    else $error("data low not captured");
  erase_c: cover property (@(posedge clk) doneOp && cmd_ff == CMD_ERASE);
  page_c: cover property (@(posedge clk) doneOp && cmd_ff == CMD_WFLASH);
  eep_c: cover property (@(posedge clk) doneOp && cmd_ff == CMD_WEEP);
  read_c: cover property (@(posedge clk) dataOe && cmd_ff == CMD_RSIG);
  nop_c: cover property (@(posedge clk) cmdLoad && din2_ff == CMD_NOP);
endmodule

//--- bench/hvp_prog_model.sv
// Purpose: behavioural external programmer for the parallel port
// Assumes: 125 MHz clk, pins moved only at rising edges
// Notes: shared data lines resolved here; released lines toggle
`timescale 1ns/1ps
module hvp_prog_model
  import hvp_pkg::*;
(
  input wire logic clk,
  input wire logic ready,
  input wire logic [7:0] dataOut,
  input wire logic dataOe,
  output hvp_pkg::hvp_pins_type pins,
  output logic [7:0] bus
);
  logic [7:0] drv = 8'h00;
  logic drvEn = 1'b1;
  logic [7:0] lastBus = 8'h00;
  // entry pattern all low, write and output enable idle high
  initial pins = hvp_pins_type'(PINS_IDLE);
  // ==========================================
  // data line resolution: nobody driving shows a changing pattern
  always_comb begin
    if (dataOe) bus = dataOut;
    else if (drvEn) bus = drv;
    else bus = ~lastBus;
  end
  always @(posedge clk) lastBus <= bus;
  // ==========================================
  // access tasks
  task automatic hold(input int n);
    repeat (n) @(posedge clk);
  endtask
  // entry pins kept still, then the long settle before any command
  task automatic enter;
    hold(37500);
  endtask
  // load, latch and write strobes held 32 cycles, 256 ns; output enable held low 8 cycles
  task automatic load(input logic [1:0] act, input logic [1:0] bs, input logic [7:0] v);
    pins.actSel <= act;
    pins.byteSel <= bs;
    drv <= v;
    drvEn <= 1'b1;
    hold(2);
    pins.loadStrobe <= 1'b1;
    hold(32);
    pins.loadStrobe <= 1'b0;
    hold(32);
  endtask
  task automatic latch;
    pins.pageLatch <= 1'b1;
    hold(32);
    pins.pageLatch <= 1'b0;
    hold(32);
  endtask
  // busy seen during the pulse; then wait for ready before going on
  task automatic write(input logic [1:0] bs, output logic busy);
    busy = 1'b0;
    pins.byteSel <= bs;
    hold(2);
    pins.writeN <= 1'b0;
    for (int i = 0; i < 32; i++) begin
      @(posedge clk);
      if (ready === 1'b0) busy = 1'b1;
    end
    pins.writeN <= 1'b1;
    for (int i = 0; i < 300 && ready !== 1'b1; i++) @(posedge clk);
    hold(4);
  endtask
  // programmer lets go of the lines while output enable is low
  task automatic read(input logic [1:0] bs, output logic [7:0] v);
    drvEn <= 1'b0;
    pins.byteSel <= bs;
    pins.outEnN <= 1'b0;
    hold(8);
    v = bus;
    pins.outEnN <= 1'b1;
    hold(8);
  endtask
endmodule

//--- bench/testbench.sv
// Purpose: directed checks of the parallel programming port
// Assumes: default memory sizes, arbitrary identity values
// Notes: one address high load serves each 256 window
`timescale 1ns/1ps
module testbench;
  import hvp_pkg::*;
  localparam logic [7:0] CAL = 8'h7c;
  localparam logic [71:0] SER = 72'h1122334455667788a9; // arbitrary serial number
  logic [7:0] sig [3] = '{8'h21, 8'h43, 8'h65}; // arbitrary identity values
  logic clk;
  logic rst;
  hvp_pins_type pins;
  logic [7:0] bus;
  logic [7:0] dataOut;
  logic [7:0] osc;
  logic dataOe;
  logic rdy;
  int err_count = 0;
  int n_checks = 0;
  int cyc = 0;
  hvp_port #(.SIG0(8'h21), .SIG1(8'h43), .SIG2(8'h65), .CAL_BYTE(CAL), .SERIAL(SER)) u_dut (
    .clk(clk), .rst(rst), .pins(pins), .dataIn(bus), .dataOut(dataOut),
    .dataOe(dataOe), .ready_busy_out(rdy), .osc_calibration_reg(osc));
  hvp_prog_model u_prog (
    .clk(clk), .ready(rdy), .dataOut(dataOut), .dataOe(dataOe), .pins(pins), .bus(bus));
  // ==========================================
  // clock and hang guard
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      err_count++;
      stop_test();
    end
  end
  // ==========================================
  // helpers
  task automatic stop_test;
    if (err_count == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic rd(input string nm, input logic [1:0] bs, input logic [7:0] e);
    logic [7:0] v;
    u_prog.read(bs, v);
    chk(nm, e, v);
    chk("dataOe", 8'h00, {7'h0, dataOe});
  endtask
  task automatic wr(input logic [1:0] bs, input logic e);
    logic b;
    u_prog.write(bs, b);
    chk("busy", {7'h0, e}, {7'h0, b});
    chk("ready", 8'h01, {7'h0, rdy});
  endtask
  task automatic cmd(input logic [7:0] c);
    u_prog.load(ACT_CMD, 2'h0, c);
  endtask
  // ==========================================
  // main sequence
  initial begin
    rst = 1'b1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    chk("osc_calibration_reg", CAL, osc);
    chk("ready", 8'h01, {7'h0, rdy});
    u_prog.enter();
    cmd(CMD_RSIG);
    for (int i = 0; i < 3; i++) begin
      u_prog.load(ACT_ADDR, 2'h0, 8'(i));
      rd("sig", 2'h0, sig[i]);
    end
    u_prog.load(ACT_ADDR, 2'h0, 8'h00);
    rd("cal", 2'h1, CAL);
    u_prog.load(ACT_ADDR, 2'h0, 8'h0e);
    rd("serial0", 2'h0, SER[7:0]);
    u_prog.load(ACT_ADDR, 2'h0, 8'h16);
    rd("serial8", 2'h0, SER[71:64]);
    cmd(CMD_RFUSE);
    rd("fuseLo", 2'h0, 8'h62);
    rd("lock", 2'h1, 8'hff);
    rd("fuseEx", 2'h2, 8'hff);
    rd("fuseHi", 2'h3, 8'h99);
    cmd(CMD_WFUSE);
    u_prog.load(ACT_DATA, 2'h0, 8'h5e);
    wr(2'h0, 1'b1);
    cmd(CMD_ERASE);
    wr(2'h0, 1'b1);
    cmd(CMD_WFLASH);
    u_prog.load(ACT_ADDR, 2'h1, 8'h00);
    for (int w = 0; w < 2; w++) begin
      u_prog.load(ACT_ADDR, 2'h0, 8'(w));
      u_prog.load(ACT_DATA, 2'h0, 8'ha0 + 8'(w));
      u_prog.load(ACT_DATA, 2'h1, 8'h50 + 8'(w));
      u_prog.latch();
    end
    wr(2'h0, 1'b1);
    cmd(CMD_NOP);
    wr(2'h0, 1'b0);
    cmd(CMD_RFLASH);
    for (int w = 0; w < 2; w++) begin
      u_prog.load(ACT_ADDR, 2'h0, 8'(w));
      rd("flashLo", 2'h0, 8'ha0 + 8'(w));
      rd("flashHi", 2'h1, 8'h50 + 8'(w));
    end
    cmd(CMD_WEEP);
    u_prog.load(ACT_ADDR, 2'h0, 8'h03);
    u_prog.load(ACT_DATA, 2'h0, 8'h6b);
    u_prog.latch();
    wr(2'h0, 1'b1);
    cmd(CMD_WFUSE);
    u_prog.load(ACT_DATA, 2'h0, 8'h91); // preserve fuse programmed
    wr(2'h1, 1'b1);
    cmd(CMD_WLOCK);
    u_prog.load(ACT_DATA, 2'h0, 8'hfc);
    wr(2'h0, 1'b1);
    cmd(CMD_RFUSE);
    rd("lock", 2'h1, 8'hfc);
    cmd(CMD_RSIG);
    u_prog.load(ACT_ADDR, 2'h0, 8'h02);
    rd("sigLocked", 2'h0, sig[2]);
    cmd(CMD_ERASE);
    wr(2'h0, 1'b1);
    cmd(CMD_RFUSE);
    rd("lock", 2'h1, 8'hff);
    rd("fuseLo", 2'h0, 8'h5e);
    rd("fuseHi", 2'h3, 8'h91);
    cmd(CMD_RFLASH);
    u_prog.load(ACT_ADDR, 2'h0, 8'h00);
    rd("flashLo", 2'h0, 8'hff);
    cmd(CMD_REEP);
    u_prog.load(ACT_ADDR, 2'h0, 8'h03);
    rd("eeprom", 2'h0, 8'h6b);
    u_prog.load(2'h3, 2'h0, 8'h00);
    rd("eepIdle", 2'h0, 8'h6b);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    chk("osc_calibration_reg", CAL, osc);
    wr(2'h0, 1'b0);
    stop_test();
  end
endmodule
